// ### verilog/exu_cfg.svh
// offsets, field positions, reset values and vector numbers of the exception unit
`ifndef EXU_CFG_SVH
`define EXU_CFG_SVH
`define EXU_OFF_VBASE    12'h000
`define EXU_OFF_STATUS   12'h004
`define EXU_OFF_PRIO_EXT 12'h008
`define EXU_OFF_PRIO_PER 12'h00C
`define EXU_OFF_INFO     12'h010
`define EXU_SR_MASK_LSB  4
`define EXU_SR_RESET     32'h0000_00F0
`define EXU_VBASE_RESET  32'h0000_0000
`define EXU_NMI_LEVEL    5'h10
`define EXU_NMI_MASK     4'hF
`define EXU_VEC_GEN_ILL  8'h04
`define EXU_VEC_SLOT_ILL 8'h06
`define EXU_VEC_ADDRERR  8'h09
`define EXU_VEC_NMI      8'h0B
`define EXU_VEC_EXT_BASE 8'h40
`define EXU_VEC_EXT_GAP  8'h02
`define EXU_VEC_PER_BASE 8'h48
`define EXU_STACK_WORD   32'h0000_0004
`define EXU_STACK_PAIR   32'h0000_0008
`endif

// ### verilog/exu_pkg.sv
// types shared by the exception unit
package exu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PUSH_SR = 3'b001,
        ST_PUSH_PC = 3'b010,
        ST_FETCH   = 3'b011,
        ST_JUMP    = 3'b100
    } exu_state_t;
    typedef enum logic [2:0] {
        CL_PLAIN   = 3'b000,
        CL_DELAYED = 3'b001,
        CL_PCMOD   = 3'b010,
        CL_TRAP    = 3'b011,
        CL_UNDEF   = 3'b100,
        CL_INTDIS  = 3'b101
    } exu_class_t;
    typedef enum logic [1:0] {
        KD_OTHER = 2'b00,
        KD_INT   = 2'b01,
        KD_NMI   = 2'b10
    } exu_kind_t;
endpackage

// ### verilog/exu_arbiter.sv
// priority arbiter: picks the highest-level pending source
`timescale 1ns/1ps
module exu_arbiter #(
    parameter int N = 15
) (
    input  wire logic [N-1:0]   reqs,
    input  wire logic [N*5-1:0] levels,
    input  wire logic [N*8-1:0] vectors,
    output logic                winValid,
    output logic [4:0]          winLevel,
    output logic [7:0]          winVec
);
    always_comb begin
        winValid = 1'b0;
        winLevel = 5'h00;
        winVec   = 8'h00;
        // scanning downward with >= lets the lowest index win a tie
        for (int i = N - 1; i >= 0; i--) begin
            if (reqs[i] && levels[i*5 +: 5] != 5'h00 && levels[i*5 +: 5] >= winLevel) begin
                winValid = 1'b1;
                winLevel = levels[i*5 +: 5];
                winVec   = vectors[i*8 +: 8];
            end
        end
    end
endmodule

// ### verilog/exu_core.sv
// exception sequencer: interrupt acceptance, instruction exceptions, stacking, vector jump
// Function
// - nmi is level 16, never masked, always accepted; code holds it in delay slots and after interrupt-disabled code
// - programmable source levels are only 0 to 15
// - maskable interrupt taken only if level exceeds status mask
// - highest-level pending request wins
// - each source owns a distinct vector number
// - interrupt stacks status word, then program counter
// - after stacking, mask field gets the accepted level
// - nmi writes all ones into the mask field
// - handler address read from vector entry, execution starts there
// - instruction exceptions stack status word, then program counter
// - trap stacks address of the following instruction
// - trap vector comes from the trap immediate
// - handler jump is immediate, no delay slot
// - undefined code in a delay slot raises illegal-slot
// - pc-modifying code in a delay slot raises illegal-slot
// - illegal-slot stacks the delayed branch target
// - undefined code elsewhere raises general illegal, stacking its own address
// - delayed branch class covers jumps, branches, returns, slot conditionals
// - address errors and interrupts held during delay slot decode
// - after interrupt-disabled code, interrupts held, address errors taken
// - held exception taken at next decode that permits it
// - interrupt-disabled class covers control/system register loads and stores
// - vector entry address is vector base plus four times vector
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "exu_cfg.svh"
module exu_core #(
    parameter int NEXT = 6,
    parameter int NPER = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 nmiPin,
    input  wire logic [NEXT-1:0]      extReqPin,
    input  wire logic [NPER-1:0]      periphReq,
    input  wire logic                 decValid,
    input  wire exu_pkg::exu_class_t  decClass,
    input  wire logic [31:0]          decPc,
    input  wire logic [31:0]          decNextPc,
    input  wire logic [31:0]          decTarget,
    input  wire logic [7:0]           decTrapVec,
    input  wire logic                 addrErrReq,
    input  wire logic                 srLoad,
    input  wire logic [31:0]          srIn,
    input  wire logic [31:0]          stackPtr,
    output logic                      excStall,
    output logic                      busReq,
    output logic                      busWrite,
    output logic [31:0]               busAddr,
    output logic [31:0]               busWdata,
    input  wire logic [31:0]          busRdata,
    input  wire logic                 busAck,
    output logic                      pcLoad,
    output logic [31:0]               pcNew,
    output logic                      spLoad,
    output logic [31:0]               spNew,
    output logic [31:0]               statusWord
);
    import exu_pkg::*;

    localparam int NSRC = 1 + NEXT + NPER;

    function automatic logic isPcMod(input exu_class_t c);
        return c == CL_DELAYED || c == CL_PCMOD || c == CL_TRAP;
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return a == `EXU_OFF_VBASE || a == `EXU_OFF_STATUS || a == `EXU_OFF_PRIO_EXT
            || a == `EXU_OFF_PRIO_PER || a == `EXU_OFF_INFO;
    endfunction

    exu_state_t       state_q, state_d;
    exu_kind_t        kind_q, kind_d;
    logic [3:0]       level_q, level_d;
    logic [7:0]       vec_q, vec_d;
    logic [31:0]      savedPc_q, savedPc_d;
    logic [31:0]      spBase_q, spBase_d;
    logic             busReq_q, busReq_d;
    logic             busWrite_q, busWrite_d;
    logic [31:0]      busAddr_q, busAddr_d;
    logic [31:0]      busWdata_q, busWdata_d;
    logic [31:0]      pcNew_q, pcNew_d;
    logic [31:0]      spNew_q, spNew_d;
    logic [31:0]      status_q, status_d;
    logic [31:0]      vbase_q, vbase_d;
    logic [NEXT*4-1:0] prioExt_q, prioExt_d;
    logic [NPER*4-1:0] prioPer_q, prioPer_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             nmiPend_q, nmiPend_d;
    logic             addrPend_q, addrPend_d;
    logic             inSlot_q, inSlot_d;
    logic             afterDis_q, afterDis_d;
    logic [31:0]      slotTarget_q, slotTarget_d;
    logic             nmiSync1_q, nmiSync2_q, nmiDly_q;
    logic [NEXT-1:0]  extSync1_q, extSync2_q;

    logic [NSRC-1:0]   srcReq;
    logic [NSRC*5-1:0] srcLvl;
    logic [NSRC*8-1:0] srcVec;
    logic             winValid;
    logic [4:0]       winLevel;
    logic [7:0]       winVec;
    logic [3:0]       srMask;
    logic             stIdle, intOk, nmiWin, addrTake, intTake, slotExc, insnExc, take, intSel;

    // pins cross in through two flops; the first flop feeds nothing else
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nmiSync1_q <= 1'b0;
            nmiSync2_q <= 1'b0;
            nmiDly_q   <= 1'b0;
            extSync1_q <= '0;
            extSync2_q <= '0;
        end else begin
            nmiSync1_q <= nmiPin;
            nmiSync2_q <= nmiSync1_q;
            nmiDly_q   <= nmiSync2_q;
            extSync1_q <= extReqPin;
            extSync2_q <= extSync1_q;
        end
    end

    // source 0 is nmi at the fixed top level; the rest take 4-bit levels only
    assign srcReq[0]   = nmiPend_q;
    assign srcLvl[4:0] = `EXU_NMI_LEVEL;
    assign srcVec[7:0] = `EXU_VEC_NMI;
    for (genvar g = 0; g < NEXT; g++) begin : gExt
        assign srcReq[1+g]         = extSync2_q[g];
        assign srcLvl[(1+g)*5 +: 5] = {1'b0, prioExt_q[g*4 +: 4]};
        // vector numbers skip a reserved pair after the fourth line
        assign srcVec[(1+g)*8 +: 8] = (g < 4) ? `EXU_VEC_EXT_BASE + 8'(g)
                                              : `EXU_VEC_EXT_BASE + `EXU_VEC_EXT_GAP + 8'(g);
    end
    for (genvar g = 0; g < NPER; g++) begin : gPer
        assign srcReq[1+NEXT+g]         = periphReq[g];
        assign srcLvl[(1+NEXT+g)*5 +: 5] = {1'b0, prioPer_q[g*4 +: 4]};
        assign srcVec[(1+NEXT+g)*8 +: 8] = `EXU_VEC_PER_BASE + 8'(g);
    end

    exu_arbiter #(
        .N (NSRC)
    ) uArb (
        .reqs     (srcReq),
        .levels   (srcLvl),
        .vectors  (srcVec),
        .winValid (winValid),
        .winLevel (winLevel),
        .winVec   (winVec)
    );

    assign srMask   = status_q[`EXU_SR_MASK_LSB +: 4];
    assign stIdle   = state_q == ST_IDLE;
    assign intOk    = !inSlot_q && !afterDis_q;
    assign nmiWin   = winLevel == `EXU_NMI_LEVEL;
    assign addrTake = decValid && addrPend_q && !inSlot_q;
    assign intTake  = decValid && intOk && winValid && (nmiWin || winLevel[3:0] > srMask);
    assign slotExc  = inSlot_q && (decClass == CL_UNDEF || isPcMod(decClass));
    assign insnExc  = decValid && (slotExc || decClass == CL_TRAP || decClass == CL_UNDEF);
    assign take     = stIdle && (addrTake || intTake || insnExc);
    assign intSel   = take && !addrTake && intTake;
    assign excStall = take || !stIdle;

    // exception sequence
    always_comb begin
        state_d    = state_q;
        kind_d     = kind_q;
        level_d    = level_q;
        vec_d      = vec_q;
        savedPc_d  = savedPc_q;
        spBase_d   = spBase_q;
        busReq_d   = busReq_q;
        busWrite_d = busWrite_q;
        busAddr_d  = busAddr_q;
        busWdata_d = busWdata_q;
        pcNew_d    = pcNew_q;
        spNew_d    = spNew_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d    = ST_PUSH_SR;
                    spBase_d   = stackPtr;
                    busReq_d   = 1'b1;
                    busWrite_d = 1'b1;
                    busAddr_d  = stackPtr - `EXU_STACK_WORD;
                    busWdata_d = status_q;
                    kind_d     = KD_OTHER;
                    level_d    = winLevel[3:0];
                    if (addrTake) begin
                        vec_d     = `EXU_VEC_ADDRERR;
                        savedPc_d = decPc;
                    end else if (intTake) begin
                        vec_d     = winVec;
                        savedPc_d = decPc;
                        kind_d    = nmiWin ? KD_NMI : KD_INT;
                    end else if (slotExc) begin
                        vec_d     = `EXU_VEC_SLOT_ILL;
                        savedPc_d = slotTarget_q;
                    end else if (decClass == CL_TRAP) begin
                        vec_d     = decTrapVec;
                        savedPc_d = decNextPc;
                    end else begin
                        vec_d     = `EXU_VEC_GEN_ILL;
                        savedPc_d = decPc;
                    end
                end
            end
            ST_PUSH_SR: begin
                if (busAck) begin
                    state_d    = ST_PUSH_PC;
                    busAddr_d  = spBase_q - `EXU_STACK_PAIR;
                    busWdata_d = savedPc_q;
                end
            end
            ST_PUSH_PC: begin
                if (busAck) begin
                    state_d    = ST_FETCH;
                    busWrite_d = 1'b0;
                    busAddr_d  = vbase_q + {22'h00_0000, vec_q, 2'b00};
                    busWdata_d = 32'h0000_0000;
                    spNew_d    = spBase_q - `EXU_STACK_PAIR;
                end
            end
            ST_FETCH: begin
                if (busAck) begin
                    state_d  = ST_JUMP;
                    busReq_d = 1'b0;
                    pcNew_d  = busRdata;
                end
            end
            ST_JUMP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            kind_q     <= KD_OTHER;
            level_q    <= 4'h0;
            vec_q      <= 8'h00;
            savedPc_q  <= 32'h0000_0000;
            spBase_q   <= 32'h0000_0000;
            busReq_q   <= 1'b0;
            busWrite_q <= 1'b0;
            busAddr_q  <= 32'h0000_0000;
            busWdata_q <= 32'h0000_0000;
            pcNew_q    <= 32'h0000_0000;
            spNew_q    <= 32'h0000_0000;
        end else begin
            state_q    <= state_d;
            kind_q     <= kind_d;
            level_q    <= level_d;
            vec_q      <= vec_d;
            savedPc_q  <= savedPc_d;
            spBase_q   <= spBase_d;
            busReq_q   <= busReq_d;
            busWrite_q <= busWrite_d;
            busAddr_q  <= busAddr_d;
            busWdata_q <= busWdata_d;
            pcNew_q    <= pcNew_d;
            spNew_q    <= spNew_d;
        end
    end

    // status word, pending flags and slot tracking
    always_comb begin
        status_d     = status_q;
        nmiPend_d    = nmiPend_q;
        addrPend_d   = addrPend_q;
        inSlot_d     = inSlot_q;
        afterDis_d   = afterDis_q;
        slotTarget_d = slotTarget_q;
        // mask changes once both words are on the stack, or by srLoad in idle
        if (state_q == ST_PUSH_PC && busAck && kind_q == KD_NMI) begin
            status_d[`EXU_SR_MASK_LSB +: 4] = `EXU_NMI_MASK;
        end else if (state_q == ST_PUSH_PC && busAck && kind_q == KD_INT) begin
            status_d[`EXU_SR_MASK_LSB +: 4] = level_q;
        end else if (srLoad && stIdle && !take) begin
            status_d = srIn;
        end
        // a new edge or error in the clearing cycle survives
        if (intSel && nmiWin) begin
            nmiPend_d = 1'b0;
        end
        if (nmiSync2_q && !nmiDly_q) begin
            nmiPend_d = 1'b1;
        end
        if (take && addrTake) begin
            addrPend_d = 1'b0;
        end
        if (addrErrReq) begin
            addrPend_d = 1'b1;
        end
        if (take) begin
            inSlot_d   = 1'b0;
            afterDis_d = 1'b0;
        end else if (decValid && stIdle) begin
            inSlot_d   = decClass == CL_DELAYED;
            afterDis_d = decClass == CL_INTDIS;
            if (decClass == CL_DELAYED) begin
                slotTarget_d = decTarget;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_q     <= `EXU_SR_RESET;
            nmiPend_q    <= 1'b0;
            addrPend_q   <= 1'b0;
            inSlot_q     <= 1'b0;
            afterDis_q   <= 1'b0;
            slotTarget_q <= 32'h0000_0000;
        end else begin
            status_q     <= status_d;
            nmiPend_q    <= nmiPend_d;
            addrPend_q   <= addrPend_d;
            inSlot_q     <= inSlot_d;
            afterDis_q   <= afterDis_d;
            slotTarget_q <= slotTarget_d;
        end
    end

    // apb slave: read data latched in setup, so no wait states
    always_comb begin
        vbase_d   = vbase_q;
        prioExt_d = prioExt_q;
        prioPer_d = prioPer_q;
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            case (paddr)
                `EXU_OFF_VBASE:    prdata_d = vbase_q;
                `EXU_OFF_STATUS:   prdata_d = status_q;
                `EXU_OFF_PRIO_EXT: prdata_d = 32'(prioExt_q);
                `EXU_OFF_PRIO_PER: prdata_d = 32'(prioPer_q);
                `EXU_OFF_INFO:     prdata_d = {21'h00_0000, state_q, vec_q};
                default:           prdata_d = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                `EXU_OFF_VBASE:    vbase_d = pwdata;
                `EXU_OFF_PRIO_EXT: prioExt_d = pwdata[NEXT*4-1:0];
                `EXU_OFF_PRIO_PER: prioPer_d = pwdata[NPER*4-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            vbase_q   <= `EXU_VBASE_RESET;
            prioExt_q <= '0;
            prioPer_q <= '0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            vbase_q   <= vbase_d;
            prioExt_q <= prioExt_d;
            prioPer_q <= prioPer_d;
            prdata_q  <= prdata_d;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !isMapped(paddr);
    assign busReq     = busReq_q;
    assign busWrite   = busWrite_q;
    assign busAddr    = busAddr_q;
    assign busWdata   = busWdata_q;
    assign pcLoad     = state_q == ST_JUMP;
    assign spLoad     = state_q == ST_JUMP;
    assign pcNew      = pcNew_q;
    assign spNew      = spNew_q;
    assign statusWord = status_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_nmi_always:
    assert property (stIdle && decValid && nmiPend_q && intOk && !addrPend_q
        |=> state_q == ST_PUSH_SR && kind_q == KD_NMI && vec_q == `EXU_VEC_NMI)
        else $error("pending nmi not accepted");
    a_level_range:
    assert property (winValid && nmiWin |-> nmiPend_q)
        else $error("level 16 won without nmi");
    a_mask_strict:
    assert property ($changed(state_q) && state_q == ST_PUSH_SR && kind_q == KD_INT |-> level_q > srMask)
        else $error("interrupt taken at or below mask");
    a_stack_order:
    assert property (state_q == ST_PUSH_SR && busAck
        |=> state_q == ST_PUSH_PC && busWrite && busAddr == spBase_q - `EXU_STACK_PAIR && busWdata == savedPc_q)
        else $error("pc not pushed after status word");
    a_first_push:
    assert property (take |=> busReq && busWrite && busAddr == $past(stackPtr) - `EXU_STACK_WORD)
        else $error("status word not pushed first");
    a_mask_level:
    assert property (state_q == ST_PUSH_PC && busAck && kind_q == KD_INT |=> srMask == $past(level_q))
        else $error("mask not loaded with level");
    a_mask_nmi:
    assert property (state_q == ST_PUSH_PC && busAck && kind_q == KD_NMI |=> srMask == `EXU_NMI_MASK)
        else $error("nmi mask not all ones");
    a_vec_fetch:
    assert property (state_q == ST_FETCH |-> !busWrite && busAddr == vbase_q + {22'h00_0000, vec_q, 2'b00})
        else $error("wrong vector entry address");
    a_jump_now:
    assert property (state_q == ST_FETCH && busAck |=> pcLoad && pcNew == $past(busRdata) ##1 !pcLoad && stIdle)
        else $error("handler jump not immediate");
    a_slot_hold:
    assert property (stIdle && decValid && inSlot_q && !slotExc |=> state_q == ST_IDLE)
        else $error("exception accepted in delay slot");
    a_dis_hold:
    assert property (stIdle && decValid && afterDis_q && addrPend_q |=> kind_q == KD_OTHER && vec_q == `EXU_VEC_ADDRERR)
        else $error("address error not taken after disabled insn");
    a_slot_pc:
    assert property (stIdle && decValid && slotExc |=> savedPc_q == $past(slotTarget_q) && vec_q == `EXU_VEC_SLOT_ILL)
        else $error("illegal slot stacks wrong pc");
    a_trap_vec:
    assert property (stIdle && decValid && decClass == CL_TRAP && !inSlot_q && !addrPend_q && !intTake
        |=> vec_q == $past(decTrapVec) && savedPc_q == $past(decNextPc))
        else $error("trap vector or return pc wrong");
endmodule

// ### sim/exu_bus_model.sv
// bus partner: takes stack writes, answers vector reads, with optional wait
`timescale 1ns/1ps
module exu_bus_model (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        busReq,
    input  wire logic        busWrite,
    input  wire logic [31:0] busAddr,
    input  wire logic [31:0] busWdata,
    output logic [31:0]      busRdata,
    output logic             busAck,
    output logic [31:0]      firstWr,
    output logic [31:0]      secondWr,
    output logic [31:0]      secondAddr
);
    logic waitQ;
    always_ff @(posedge ref_clk) begin
        // read data toggles between answers so a stale sample never matches
        busRdata <= ~busRdata;
        if (!resetn) begin
            busAck <= 1'b0;
            waitQ <= 1'b0;
            busRdata <= 32'h0000_0000;
        end else if (busReq && !busAck && (waitQ || !slow)) begin
            busAck <= 1'b1;
            waitQ <= 1'b0;
            if (!busWrite) busRdata <= ~busAddr;
        end else begin
            busAck <= 1'b0;
            waitQ <= busReq && !busAck;
        end
        if (busAck && busWrite) begin
            firstWr <= secondWr;
            secondWr <= busWdata;
            secondAddr <= busAddr;
        end
    end
endmodule

// ### sim/tb_top.sv
// self-checking bench of the exception sequencer
`timescale 1ns/1ps
module tb_top;
    import exu_pkg::*;
    typedef struct packed {
        exu_class_t cls; logic slot; logic [3:0] mask; logic [7:0] per; logic [5:0] ext; logic nmi;
        logic [7:0] vec; logic [31:0] pc; logic [3:0] newMask;
    } exu_row_t;
    localparam logic [31:0] PC = 32'h0000_0100, NPC = 32'h0000_0102, TGT = 32'h0000_0200;
    localparam logic [31:0] SP = 32'h0000_1000, VB = 32'h0000_4000;
    logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic        nmiPin = 1'b0, decValid = 1'b0, addrErrReq = 1'b0, srLoad = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, srIn = 32'h0000_0000, rd;
    logic [5:0]  extReqPin = 6'h00;
    logic [7:0]  periphReq = 8'h00;
    exu_class_t  decClass = CL_PLAIN;
    logic        pready, pslverr, excStall, busReq, busWrite, busAck, pcLoad, spLoad;
    logic [31:0] prdata, busAddr, busWdata, busRdata, pcNew, spNew, statusWord, firstWr, secondWr, secondAddr;
    exu_row_t    rows [10];
    int          errors = 0, tests_run = 0, i;
    exu_core exu_core_inst (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .nmiPin, .extReqPin, .periphReq, .decValid, .decClass, .decPc(PC), .decNextPc(NPC),
        .decTarget(TGT), .decTrapVec(8'h21), .addrErrReq, .srLoad, .srIn, .stackPtr(SP), .excStall, .busReq,
        .busWrite, .busAddr, .busWdata, .busRdata, .busAck, .pcLoad, .pcNew, .spLoad, .spNew, .statusWord);
    exu_bus_model exu_bus_model_inst (.ref_clk, .resetn, .slow, .busReq, .busWrite, .busAddr, .busWdata,
        .busRdata, .busAck, .firstWr, .secondWr, .secondAddr);
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic summarize;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic setMask(input logic [3:0] m);
        srLoad <= 1'b1; srIn <= {24'h0, m, 4'h0};
        @(posedge ref_clk);
        srLoad <= 1'b0;
        @(posedge ref_clk);
    endtask
    // vec zero means the decode must pass without an exception
    task automatic decode(input exu_class_t c, input logic [7:0] vec, input logic [31:0] pc, input logic [3:0] m);
        int n;
        logic [31:0] sr;
        sr = statusWord;
        decClass <= c; decValid <= 1'b1;
        @(posedge ref_clk);
        if (vec == 8'h00) check({31'h0, excStall}, 32'h0, "stall");
        for (n = 0; n < 40 && vec != 8'h00 && pcLoad !== 1'b1; n++) @(posedge ref_clk);
        decValid <= 1'b0;
        if (vec != 8'h00) begin
            check(pcNew, ~(VB + {22'h0, vec, 2'b00}), "handler");
            check(firstWr, sr, "stacked status");
            check(secondWr, pc, "stacked pc");
            check(secondAddr, SP - 32'h0000_0008, "stack top");
            check(spNew, SP - 32'h0000_0008, "new sp");
            check({31'h0, spLoad}, 32'h0000_0001, "sp load");
            check({28'h0, statusWord[7:4]}, {28'h0, m}, "mask");
        end
        @(posedge ref_clk);
    endtask
    task automatic addrErr;
        addrErrReq <= 1'b1;
        @(posedge ref_clk);
        addrErrReq <= 1'b0;
    endtask
    initial begin
        rows = '{'{CL_TRAP, 1'b0, 4'hF, 8'h00, 6'h00, 1'b0, 8'h21, NPC, 4'hF},
            '{CL_UNDEF, 1'b0, 4'hF, 8'h00, 6'h00, 1'b0, 8'h04, PC, 4'hF},
            '{CL_UNDEF, 1'b1, 4'hF, 8'h00, 6'h00, 1'b0, 8'h06, TGT, 4'hF},
            '{CL_PCMOD, 1'b1, 4'hF, 8'h00, 6'h00, 1'b0, 8'h06, TGT, 4'hF},
            '{CL_TRAP, 1'b1, 4'hF, 8'h00, 6'h00, 1'b0, 8'h06, TGT, 4'hF},
            '{CL_PLAIN, 1'b0, 4'h0, 8'h06, 6'h00, 1'b0, 8'h49, PC, 4'h9},
            '{CL_PLAIN, 1'b0, 4'h5, 8'h01, 6'h00, 1'b0, 8'h00, PC, 4'h0},
            '{CL_PLAIN, 1'b0, 4'h4, 8'h01, 6'h00, 1'b0, 8'h48, PC, 4'h5},
            '{CL_PLAIN, 1'b0, 4'h2, 8'h00, 6'h01, 1'b0, 8'h40, PC, 4'h3},
            '{CL_PLAIN, 1'b0, 4'hF, 8'h02, 6'h00, 1'b1, 8'h0B, PC, 4'hF}};
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check(statusWord, 32'h0000_00F0, "status reset");
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0, "base reset");
        apb(1'b1, 12'h000, VB);
        apb(1'b1, 12'h008, 32'hAB00_0003);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0000_0003, "ext levels");
        check({31'h0, err}, 32'h0, "mapped");
        apb(1'b1, 12'h00C, 32'h0000_0995);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h0000_0995, "per levels");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0000_00F0, "status read");
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped");
        for (i = 0; i < 10; i++) begin
            setMask(rows[i].mask);
            periphReq <= rows[i].per; extReqPin <= rows[i].ext; nmiPin <= rows[i].nmi;
            repeat (4) @(posedge ref_clk);
            if (rows[i].slot) decode(CL_DELAYED, 8'h00, PC, 4'h0);
            decode(rows[i].cls, rows[i].vec, rows[i].pc, rows[i].newMask);
            periphReq <= 8'h00; extReqPin <= 6'h00; nmiPin <= 1'b0;
        end
        slow <= 1'b1;
        setMask(4'h0);
        decode(CL_DELAYED, 8'h00, PC, 4'h0);
        periphReq <= 8'h01;
        decode(CL_PLAIN, 8'h00, PC, 4'h0);
        decode(CL_PLAIN, 8'h48, PC, 4'h5);
        // request must rise only after the disabling instruction, or that one is interrupted itself
        periphReq <= 8'h00;
        setMask(4'h0);
        decode(CL_INTDIS, 8'h00, PC, 4'h0);
        periphReq <= 8'h01;
        decode(CL_PLAIN, 8'h00, PC, 4'h0);
        decode(CL_PLAIN, 8'h48, PC, 4'h5);
        periphReq <= 8'h00;
        decode(CL_DELAYED, 8'h00, PC, 4'h0);
        addrErr();
        decode(CL_PLAIN, 8'h00, PC, 4'h0);
        decode(CL_PLAIN, 8'h09, PC, 4'h5);
        decode(CL_INTDIS, 8'h00, PC, 4'h0);
        addrErr();
        decode(CL_PLAIN, 8'h09, PC, 4'h5);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check(statusWord, 32'h0000_00F0, "status second reset");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end
endmodule
